// file: hw/lsd_limit_queue.sv
// Purpose: Consecutive out-of-limit counter for one channel
// Assumes: conv_end is a one-cycle pulse at the end of each conversion
// Notes:   met_q holds its value between conversions
`timescale 1ns/1ns
`default_nettype none
module lsd_limit_queue
#(
	parameter int CNT_W = 3
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             conv_end,
	input  wire logic             out_now,
	input  wire logic [CNT_W-1:0] need,
	output var  logic             met_q
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	// Saturate so a long fault never wraps back below the threshold
	always_comb
	begin
		cnt_d = cnt_q;
		if (out_now && (cnt_q != {CNT_W{1'b1}}))
			cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		else if (!out_now)
			cnt_d = '0;
	end

	// Counter advances only on conversion boundaries
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			met_q <= 1'b0;
		end
		else if (conv_end)
		begin
			cnt_q <= cnt_d;
			met_q <= out_now && (cnt_d >= need);
		end
	end
endmodule
`default_nettype wire

// file: hw/lsd_top.sv
// Purpose: Limit status flags, limit/critical outputs and diode gain/ideality config
// Assumes: Register port driven by the serial protocol engine on SYS_CLK;
//          comparator results and CONV_TICK come from the analog path, asynchronous
// Notes:   Flags update at the rising edge of CONV_TICK (end of conversion)
`timescale 1ns/1ns
`default_nettype none
`include "lsd_cfg.svh"
module lsd_top
(
	input  wire logic       SYS_CLK,
	input  wire logic       RST,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_WDATA,
	output var  logic [7:0] REG_RDATA,
	input  wire logic       CONV_TICK,
	input  wire logic [3:0] CMP_HIGH,
	input  wire logic [3:0] CMP_LOW,
	input  wire logic [3:0] CMP_CRIT,
	input  wire logic [3:0] CMP_CRIT_CLEAR,
	input  wire logic [3:0] GAIN_AUTO_PICK,
	input  wire logic [3:0] CHAN_MASK,
	input  wire logic       ALERT_COMPARATOR,
	input  wire logic [2:0] CONSEC_CODE,
	output var  logic       ALERT_N,
	output var  logic       CRITICAL_OUT_N,
	output var  logic       HIGH_SUMMARY,
	output var  logic       LOW_SUMMARY,
	output var  logic       CRIT_SUMMARY,
	output var  logic [3:0] GAIN_COMP_SETTING,
	output var  logic       GAIN_COMP_ACTIVE,
	output var  logic [2:0] IDEALITY_SELECT
);
	localparam int SYNC_W = 21;

	logic [SYNC_W-1:0]     sync1_q;
	logic [SYNC_W-1:0]     sync2_q;
	logic                  tick_last_q;
	logic                  conv_end;
	lsd_pkg::lsd_chan_type high_s;
	lsd_pkg::lsd_chan_type low_s;
	lsd_pkg::lsd_chan_type crit_s;
	lsd_pkg::lsd_chan_type crit_clr_s;
	lsd_pkg::lsd_chan_type pick_s;
	lsd_pkg::lsd_reg_sel_type sel;
	logic                  wr_gain;
	logic                  rd_upper;
	logic                  rd_lower;
	logic                  gain_auto_q;
	logic [3:0]            gain_set_q;
	logic [2:0]            ideal_sel_q;
	lsd_pkg::lsd_chan_type upper_q;
	lsd_pkg::lsd_chan_type upper_d;
	lsd_pkg::lsd_chan_type lower_q;
	lsd_pkg::lsd_chan_type lower_d;
	lsd_pkg::lsd_chan_type crit_q;
	lsd_pkg::lsd_chan_type crit_d;
	lsd_pkg::lsd_chan_type queue_met;
	lsd_pkg::lsd_chan_type queue_in;
	lsd_pkg::lsd_count_type need;
	logic                  low_sum_q;
	logic [7:0]            rdata_d;

	// Place the four channel bits at positions 7, 6, 1 and 0
	function automatic logic [7:0] pack_flags(input lsd_pkg::lsd_chan_type v);
		pack_flags = {v[3], v[2], 4'h0, v[1], v[0]};
	endfunction

	// Unlisted queue codes fall back to a single conversion
	function automatic lsd_pkg::lsd_count_type queue_need(input logic [2:0] code);
		case (code)
			`LSD_CODE_ONE:   queue_need = `LSD_QUEUE_ONE;
			`LSD_CODE_TWO:   queue_need = `LSD_QUEUE_TWO;
			`LSD_CODE_THREE: queue_need = `LSD_QUEUE_THREE;
			`LSD_CODE_FOUR:  queue_need = `LSD_QUEUE_FOUR;
			default:         queue_need = `LSD_QUEUE_ONE;
		endcase
	endfunction

	// Two-flop synchroniser for everything from the analog path
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			sync1_q     <= '0;
			sync2_q     <= '0;
			tick_last_q <= 1'b0;
		end
		else
		begin
			sync1_q     <= {CONV_TICK, CMP_HIGH, CMP_LOW, CMP_CRIT, CMP_CRIT_CLEAR,
				GAIN_AUTO_PICK};
			sync2_q     <= sync1_q;
			tick_last_q <= sync2_q[20];
		end
	end

	// Comparisons travel with the tick so they line up at the edge
	assign high_s     = sync2_q[19:16];
	assign low_s      = sync2_q[15:12];
	assign crit_s     = sync2_q[11:8];
	assign crit_clr_s = sync2_q[7:4];
	assign pick_s     = sync2_q[3:0];
	assign conv_end   = sync2_q[20] && !tick_last_q;

	// Address decode of the register port
	always_comb
	begin
		case (REG_ADDR)
			`LSD_ADDR_GAIN:  sel = lsd_pkg::LSD_REG_GAIN;
			`LSD_ADDR_IDEAL: sel = lsd_pkg::LSD_REG_IDEAL;
			`LSD_ADDR_UPPER: sel = lsd_pkg::LSD_REG_UPPER;
			`LSD_ADDR_LOWER: sel = lsd_pkg::LSD_REG_LOWER;
			`LSD_ADDR_CRIT:  sel = lsd_pkg::LSD_REG_CRIT;
			default:         sel = lsd_pkg::LSD_REG_NONE;
		endcase
	end

	assign wr_gain  = REG_WR && (sel == lsd_pkg::LSD_REG_GAIN);
	assign rd_upper = REG_RD && (sel == lsd_pkg::LSD_REG_UPPER);
	assign rd_lower = REG_RD && (sel == lsd_pkg::LSD_REG_LOWER);

	// Gain compensation config; the auto pick wins over a same-cycle write
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			gain_auto_q <= 1'(`LSD_RST_GAIN >> `LSD_GAIN_AUTO_BIT);
			gain_set_q  <= 4'(`LSD_RST_GAIN & 8'h0F);
		end
		else
		begin
			if (wr_gain)
				gain_auto_q <= REG_WDATA[`LSD_GAIN_AUTO_BIT];
			if (gain_auto_q && conv_end)
				gain_set_q <= pick_s;
			else if (wr_gain && !gain_auto_q)
				gain_set_q <= REG_WDATA[3:0];
		end
	end

	// Ideality select; upper bits are fixed and not stored
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			ideal_sel_q <= 3'(`LSD_RST_IDEAL & 8'h07);
		else if (REG_WR && (sel == lsd_pkg::LSD_REG_IDEAL))
			ideal_sel_q <= REG_WDATA[2:0];
	end

	// Upper flags: sticky, or following the condition in comparator mode
	always_comb
	begin
		if (ALERT_COMPARATOR)
			upper_d = conv_end ? high_s : upper_q;
		else
		begin
			upper_d = rd_upper ? (upper_q & high_s) : upper_q;
			if (conv_end)
				upper_d = upper_d | high_s;
		end
	end

	// Lower flags: set wins over the clear of a read
	always_comb
	begin
		lower_d = rd_lower ? `LSD_RST_FLAGS : lower_q;
		if (conv_end)
			lower_d = lower_d | low_s;
	end

	// Critical flags: reads do not touch them, hysteresis compare clears
	always_comb
	begin
		crit_d = crit_q;
		if (conv_end)
			crit_d = (crit_q & ~crit_clr_s) | crit_s;
	end

	// Flag registers and summaries, one cycle after their cause
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			upper_q   <= `LSD_RST_FLAGS;
			lower_q   <= `LSD_RST_FLAGS;
			crit_q    <= `LSD_RST_FLAGS;
			low_sum_q <= 1'b0;
		end
		else
		begin
			upper_q   <= upper_d;
			lower_q   <= lower_d;
			crit_q    <= crit_d;
			low_sum_q <= (|lower_d) || (low_sum_q && !(rd_lower && !(|low_s)));
		end
	end

	// Low faults do not count in comparator mode
	assign queue_in = high_s | (ALERT_COMPARATOR ? `LSD_RST_FLAGS : low_s);
	assign need     = queue_need(CONSEC_CODE);

	// Per-channel consecutive counters
	for (genvar i = 0; i < 4; i++)
	begin : g_queue
		lsd_limit_queue #(.CNT_W(3)) lsd_limit_queue_inst
		(
			.clk     (SYS_CLK),
			.rst     (RST),
			.conv_end(conv_end),
			.out_now (queue_in[i]),
			.need    (need),
			.met_q   (queue_met[i])
		);
	end

	// Outputs come straight from flops
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			ALERT_N           <= 1'b1;
			CRITICAL_OUT_N    <= 1'b1;
			HIGH_SUMMARY      <= 1'b0;
			LOW_SUMMARY       <= 1'b0;
			CRIT_SUMMARY      <= 1'b0;
			GAIN_COMP_SETTING <= 4'(`LSD_RST_GAIN & 8'h0F);
			GAIN_COMP_ACTIVE  <= 1'b1;
			IDEALITY_SELECT   <= 3'(`LSD_RST_IDEAL & 8'h07);
		end
		else
		begin
			ALERT_N <= !(|((upper_q | (ALERT_COMPARATOR ? `LSD_RST_FLAGS : lower_q))
				& ~CHAN_MASK & queue_met));
			CRITICAL_OUT_N    <= !(|crit_q);
			HIGH_SUMMARY      <= |upper_q;
			LOW_SUMMARY       <= low_sum_q;
			CRIT_SUMMARY      <= |crit_q;
			GAIN_COMP_SETTING <= gain_set_q;
			GAIN_COMP_ACTIVE  <= gain_set_q != `LSD_GAIN_COMP_OFF;
			IDEALITY_SELECT   <= ideal_sel_q;
		end
	end

	// Read data mux; unmapped addresses read zero
	always_comb
	begin
		case (sel)
			lsd_pkg::LSD_REG_GAIN:  rdata_d = {3'h0, gain_auto_q, gain_set_q};
			lsd_pkg::LSD_REG_IDEAL: rdata_d = {`LSD_IDEAL_FIXED, ideal_sel_q};
			lsd_pkg::LSD_REG_UPPER: rdata_d = pack_flags(upper_q);
			lsd_pkg::LSD_REG_LOWER: rdata_d = pack_flags(lower_q);
			lsd_pkg::LSD_REG_CRIT:  rdata_d = pack_flags(crit_q);
			default:                rdata_d = `LSD_RD_NONE;
		endcase
	end

	// Read data is valid the cycle after REG_RD and then holds
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			REG_RDATA <= `LSD_RD_NONE;
		else if (REG_RD)
			REG_RDATA <= rdata_d;
	end

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	sequence s_conv_high;
		conv_end && !ALERT_COMPARATOR ##0 (high_s != 4'h0);
	endsequence
	sequence s_unmasked_flag;
		(|(upper_q & ~CHAN_MASK & queue_met)) && !ALERT_COMPARATOR;
	endsequence

	chk_gain_auto_write: assert property (
		wr_gain && gain_auto_q && !conv_end |=> $stable(gain_set_q))
		else $error("gain setting changed by a write while auto is on");
	chk_gain_auto_pick: assert property (
		conv_end && gain_auto_q |=> gain_set_q == $past(pick_s) ##1
			GAIN_COMP_SETTING == $past(gain_set_q))
		else $error("auto picked setting not applied");
	chk_gain_manual: assert property (
		wr_gain && !gain_auto_q |=> gain_set_q == $past(REG_WDATA[3:0]) ##1
			GAIN_COMP_ACTIVE == ($past(gain_set_q) != 4'hF))
		else $error("manual gain setting not taken");
	chk_upper_set_flag: assert property (
		s_conv_high |=> (upper_q & $past(high_s)) == $past(high_s) ##1 HIGH_SUMMARY)
		else $error("upper flag or summary not set");
	chk_upper_read_clear: assert property (
		rd_upper && !conv_end && !ALERT_COMPARATOR |=> upper_q == ($past(upper_q) & $past(high_s)))
		else $error("upper read cleared a present condition");
	chk_lower_read_clear: assert property (
		rd_lower && !conv_end |=> lower_q == 4'h0)
		else $error("lower flags not cleared by read");
	chk_crit_read_keep: assert property (
		REG_RD && sel == lsd_pkg::LSD_REG_CRIT && !conv_end |=> $stable(crit_q))
		else $error("critical flags changed by a read");
	chk_crit_pin_drive: assert property (
		crit_q != 4'h0 |=> !CRITICAL_OUT_N && CRIT_SUMMARY)
		else $error("critical output not asserted");
	chk_crit_summary_hold: assert property (
		CRIT_SUMMARY |-> $past(crit_q) != 4'h0)
		else $error("critical summary without a flag");
	chk_alert_raise: assert property (
		s_unmasked_flag |=> !ALERT_N)
		else $error("limit output not asserted");
	chk_alert_masked: assert property (
		(CHAN_MASK == 4'hF) [*2] |-> ALERT_N)
		else $error("masked channels drove the limit output");
endmodule
`default_nettype wire

// file: shared/lsd_cfg.svh
// Purpose: Offsets, reset values and field positions of the limit status and diode config bank
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH
`define LSD_ADDR_GAIN      8'h25
`define LSD_ADDR_IDEAL     8'h27
`define LSD_ADDR_UPPER     8'h35
`define LSD_ADDR_LOWER     8'h36
`define LSD_ADDR_CRIT      8'h37
`define LSD_RST_GAIN       8'h10
`define LSD_RST_IDEAL      8'h12
`define LSD_GAIN_AUTO_BIT  4
`define LSD_GAIN_COMP_OFF  4'hF
`define LSD_IDEAL_FIXED    5'h02
`define LSD_RST_FLAGS      4'h0
`define LSD_RD_NONE        8'h00
`define LSD_CRIT_HYST_RST  8'h0A
`define LSD_QUEUE_ONE      3'h1
`define LSD_QUEUE_TWO      3'h2
`define LSD_QUEUE_THREE    3'h3
`define LSD_QUEUE_FOUR     3'h4
`define LSD_CODE_ONE       3'h0
`define LSD_CODE_TWO       3'h1
`define LSD_CODE_THREE     3'h3
`define LSD_CODE_FOUR      3'h7
`endif

// file: shared/lsd_pkg.sv
// Purpose: Shared types of the limit status and diode config bank
// Assumes: Channel order sense volt, source volt, ext diode, int diode (index 3..0)
// Notes:   Constants live in lsd_cfg.svh
`default_nettype none
package lsd_pkg;
	typedef logic [3:0] lsd_chan_type;
	typedef logic [2:0] lsd_count_type;
	typedef enum logic [2:0]
	{
		LSD_REG_NONE  = 3'h0,
		LSD_REG_GAIN  = 3'h1,
		LSD_REG_IDEAL = 3'h3,
		LSD_REG_UPPER = 3'h2,
		LSD_REG_LOWER = 3'h6,
		LSD_REG_CRIT  = 3'h7
	} lsd_reg_sel_type;
endpackage
`default_nettype wire

// file: tb/limit_status_and_diode_config_tb.sv
// Purpose: Self-checking bench of the limit status and diode config bank
// Assumes: Reads answer one cycle after the strobe; conversions via the model
// Notes:   Expected values are queued by the drivers and popped by a watcher
`timescale 1ns/1ns
`default_nettype none
`include "lsd_cfg.svh"
module limit_status_and_diode_config_tb;
	logic        SYS_CLK, RST, REG_WR, REG_RD, ALERT_COMPARATOR, CONV_TICK;
	logic        ALERT_N, CRITICAL_OUT_N, HIGH_SUMMARY, LOW_SUMMARY, CRIT_SUMMARY;
	logic        GAIN_COMP_ACTIVE, start, snap, rd_q, busy, e_auto;
	logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA;
	logic [3:0]  CHAN_MASK, GAIN_COMP_SETTING, e_set, e_pick;
	logic [2:0]  CONSEC_CODE, IDEALITY_SELECT, e_id;
	logic [19:0] vals, levels;
	logic [7:0]  rd_exp[$];
	logic [12:0] st_exp[$];
	logic [7:0]  idv[4] = '{8'h17, 8'h10, 8'hFF, 8'h12};
	logic [2:0]  cc[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
	int          mismatches, n_tests;

	lsd_top lsd_top_inst
	(
		.SYS_CLK           (SYS_CLK),
		.RST               (RST),
		.REG_ADDR          (REG_ADDR),
		.REG_WR            (REG_WR),
		.REG_RD            (REG_RD),
		.REG_WDATA         (REG_WDATA),
		.REG_RDATA         (REG_RDATA),
		.CONV_TICK         (CONV_TICK),
		.CMP_HIGH          (levels[19:16]),
		.CMP_LOW           (levels[15:12]),
		.CMP_CRIT          (levels[11:8]),
		.CMP_CRIT_CLEAR    (levels[7:4]),
		.GAIN_AUTO_PICK    (levels[3:0]),
		.CHAN_MASK         (CHAN_MASK),
		.ALERT_COMPARATOR  (ALERT_COMPARATOR),
		.CONSEC_CODE       (CONSEC_CODE),
		.ALERT_N           (ALERT_N),
		.CRITICAL_OUT_N    (CRITICAL_OUT_N),
		.HIGH_SUMMARY      (HIGH_SUMMARY),
		.LOW_SUMMARY       (LOW_SUMMARY),
		.CRIT_SUMMARY      (CRIT_SUMMARY),
		.GAIN_COMP_SETTING (GAIN_COMP_SETTING),
		.GAIN_COMP_ACTIVE  (GAIN_COMP_ACTIVE),
		.IDEALITY_SELECT   (IDEALITY_SELECT)
	);

	lsd_conv_model lsd_conv_model_inst
	(
		.clk    (SYS_CLK),
		.rst    (RST),
		.start  (start),
		.vals   (vals),
		.tick   (CONV_TICK),
		.levels (levels),
		.busy   (busy)
	);

	// 125 MHz system clock
	initial
	begin
		SYS_CLK = 1'b0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end

	task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR read data expected %h seen %h", e, g);
		end
	endtask

	task automatic cmp_st(input logic [12:0] e, input logic [12:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR status outputs expected %h seen %h", e, g);
		end
	endtask

	// Watcher: sampled mid-cycle so registered outputs have settled
	always @(posedge SYS_CLK) rd_q <= REG_RD;
	always @(negedge SYS_CLK)
	begin
		if (rd_q)
			cmp_rd(rd_exp.pop_front(), REG_RDATA);
		if (snap)
			cmp_st(st_exp.pop_front(), {ALERT_N, CRITICAL_OUT_N, HIGH_SUMMARY,
				LOW_SUMMARY, CRIT_SUMMARY, GAIN_COMP_ACTIVE, GAIN_COMP_SETTING,
				IDEALITY_SELECT});
	end

	// Write tracks what the gain and ideality fields should now hold
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
		if (a == `LSD_ADDR_GAIN && !e_auto)
			e_set = d[3:0];
		if (a == `LSD_ADDR_GAIN)
			e_auto = d[4];
		if (a == `LSD_ADDR_IDEAL)
			e_id = d[2:0];
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_exp.push_back(e);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
	endtask

	// One conversion: c is {high, low, crit, crit clear}, pick is random
	task automatic conv(input logic [15:0] c);
		int k = 0;
		e_pick = 4'($urandom);
		@(posedge SYS_CLK);
		vals <= {c, e_pick};
		start <= 1'b1;
		@(posedge SYS_CLK);
		start <= 1'b0;
		if (e_auto)
			e_set = e_pick;
		while (busy && k < 40)
		begin
			@(negedge SYS_CLK);
			k++;
		end
		// A stuck frame is a failure, not just a slow one
		if (busy)
		begin
			mismatches++;
			$display("ERROR conversion busy expected 0 seen %b", busy);
		end
		repeat (3) @(posedge SYS_CLK);
	endtask

	// s is {alert_n, critical_n, high, low, crit summaries}
	task automatic st(input logic [4:0] s);
		st_exp.push_back({s, e_set != `LSD_GAIN_COMP_OFF, e_set, e_id});
		repeat (3) @(posedge SYS_CLK);
		snap <= 1'b1;
		@(posedge SYS_CLK);
		snap <= 1'b0;
	endtask

	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog: far beyond the roughly 10 us the sequence needs
	initial
	begin
		#200000;
		mismatches++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		RST = 1'b1;
		{REG_WR, REG_RD, ALERT_COMPARATOR, start, snap} = 5'h00;
		{REG_ADDR, REG_WDATA, CHAN_MASK, CONSEC_CODE, vals} = 43'h0;
		{mismatches, n_tests} = 64'h0;
		{e_auto, e_set, e_id} = 8'h82;
		void'($urandom(32'h951C));
		repeat (3) @(posedge SYS_CLK);
		RST <= 1'b0;
		rd(`LSD_ADDR_GAIN, `LSD_RST_GAIN);
		rd(`LSD_ADDR_IDEAL, `LSD_RST_IDEAL);
		rd(`LSD_ADDR_UPPER, 8'h00);
		rd(`LSD_ADDR_LOWER, 8'h00);
		rd(`LSD_ADDR_CRIT, 8'h00);
		rd(8'h40, 8'h00);
		st(5'h18);
		wr(`LSD_ADDR_GAIN, 8'h1A);
		rd(`LSD_ADDR_GAIN, 8'h10);
		conv(16'h0000);
		rd(`LSD_ADDR_GAIN, {3'h0, e_auto, e_set});
		st(5'h18);
		wr(`LSD_ADDR_GAIN, 8'h00);
		// Every manual code; the last one is the discrete-diode setting
		for (int c = 0; c < 16; c++)
		begin
			wr(`LSD_ADDR_GAIN, 8'(c));
			conv(16'h0000);
			rd(`LSD_ADDR_GAIN, {3'h0, e_auto, e_set});
			st(5'h18);
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(`LSD_ADDR_IDEAL, idv[i]);
			rd(`LSD_ADDR_IDEAL, {`LSD_IDEAL_FIXED, e_id});
		end
		st(5'h18);
		conv(16'h2000);
		rd(`LSD_ADDR_UPPER, 8'h02);
		st(5'h0C);
		conv(16'h0000);
		rd(`LSD_ADDR_UPPER, 8'h02);
		rd(`LSD_ADDR_UPPER, 8'h00);
		st(5'h18);
		conv(16'h8000);
		rd(`LSD_ADDR_UPPER, 8'h80);
		rd(`LSD_ADDR_UPPER, 8'h80);
		conv(16'h0000);
		rd(`LSD_ADDR_UPPER, 8'h80);
		rd(`LSD_ADDR_UPPER, 8'h00);
		conv(16'h0500);
		st(5'h0A);
		rd(`LSD_ADDR_LOWER, 8'h41);
		rd(`LSD_ADDR_LOWER, 8'h00);
		st(5'h1A);
		conv(16'h0000);
		rd(`LSD_ADDR_LOWER, 8'h00);
		st(5'h18);
		CHAN_MASK <= 4'h2;
		conv(16'h2020);
		st(5'h15);
		conv(16'h0090);
		rd(`LSD_ADDR_UPPER, 8'h02);
		rd(`LSD_ADDR_CRIT, 8'h83);
		rd(`LSD_ADDR_CRIT, 8'h83);
		conv(16'h0003);
		rd(`LSD_ADDR_CRIT, 8'h80);
		st(5'h11);
		conv(16'h0008);
		rd(`LSD_ADDR_CRIT, 8'h00);
		st(5'h18);
		CHAN_MASK <= 4'h0;
		// Each consecutive count: output holds off until the last conversion
		for (int i = 0; i < 4; i++)
		begin
			CONSEC_CODE <= cc[i];
			for (int k = 0; k <= i; k++)
			begin
				conv(16'h1000);
				st({k != i, 4'hC});
			end
			conv(16'h0000);
			rd(`LSD_ADDR_UPPER, 8'h01);
		end
		// Unlisted count code must behave as a single conversion
		ALERT_COMPARATOR <= 1'b1;
		CONSEC_CODE <= 3'h5;
		conv(16'h1000);
		st(5'h0C);
		conv(16'h0000);
		rd(`LSD_ADDR_UPPER, 8'h00);
		st(5'h18);
		// All channels masked: flag and summary rise, limit output stays idle
		CHAN_MASK <= 4'hF;
		conv(16'h1000);
		st(5'h1C);
		stop_test();
	end
endmodule
`default_nettype wire

// file: tb/lsd_conv_model.sv
// Purpose: Analog path stand-in: comparator levels, auto gain pick, conversion tick
// Assumes: start is a one-cycle pulse; levels hold until the next start
// Notes:   Tick idles low between conversions, high 32 ns inside one
`timescale 1ns/1ns
`default_nettype none
module lsd_conv_model
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [19:0] vals,
	output var  logic        tick,
	output var  logic [19:0] levels,
	output var  logic        busy
);
	logic [3:0] cnt_q;

	// Levels settle before the tick rises and outlast the sync delay
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 4'h0;
			tick <= 1'b0;
			levels <= 20'h00000;
		end
		else
		begin
			if (start)
				levels <= vals;
			if (start || cnt_q != 4'h0)
				cnt_q <= cnt_q + 4'h1;
			tick <= (cnt_q >= 4'h3) && (cnt_q < 4'h7);
		end
	end

	// Busy spans the whole frame so the bench never overlaps ticks
	assign busy = start || (cnt_q != 4'h0);
endmodule
`default_nettype wire
